//--- cas_pkg.sv
// Purpose: Shared constants for the commutation and step output block
// Assumes: 10 MHz system clock, positions in encoder counts
// Notes: Phase and cycle values are unsigned fixed point with FRAC_W bits
package cas_pkg;
    // Fixed point layout of cycle length and phase
    localparam int FRAC_W = 8;
    localparam int POS_W = 32;
    // Clock and millisecond timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1_000_000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    // Reset values
    localparam logic [31:0] CYCLE_RST = 32'h0000_0000;
    localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
    // Twelfths of a magnetic cycle, used for 30 and 60 degree steps
    localparam logic [3:0] TWELFTHS = 4'hC;
    // Motor type codes for stepper polarity
    localparam logic signed [2:0] MTYPE_STEP_LOW = 3'sh2;
    localparam logic signed [2:0] MTYPE_STEP_HIGH = -3'sh2;
    // Smoothing thresholds in half units
    localparam logic [4:0] SMOOTH_1 = 5'h0_2;
    localparam logic [4:0] SMOOTH_2 = 5'h0_4;
    localparam logic [4:0] SMOOTH_4 = 5'h0_8;
    localparam logic [4:0] SMOOTH_8 = 5'h1_0;
    // Sequencer states, Gray coded along test A, test B, zero drive
    typedef enum logic [1:0] {
        CAS_IDLE = 2'b00,
        CAS_TEST_A = 2'b01,
        CAS_TEST_B = 2'b11,
        CAS_ZERO = 2'b10
    } cas_state_t;
endpackage

//--- cas_commutation_step.sv
// Purpose: Commutation set-up, phase tracking and step pulse output
// Assumes: Inputs synchronous to clk_i, encoder deltas small per cycle
// Notes: Phase and cycle values are Q24.8 encoder counts
`timescale 1ns/1ns
module cas_commutation_step import cas_pkg::*; #(
    parameter int N_AXES = 7,
    parameter int CYC_MS = CYC_PER_MS,
    parameter int ACC_W = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [N_AXES-1:0] sine_axis_mask_i,
    input wire logic cycle_len_load_i,
    input wire logic [31:0] magnetic_cycle_length_i,
    input wire logic hall_present_i,
    input wire logic [2:0] hall_i,
    input wire logic signed [POS_W-1:0] encoder_position_i,
    input wire logic setup_start_i,
    input wire logic signed [15:0] setup_volt_i,
    input wire logic [15:0] setup_ms_i,
    input wire logic hall_offset_load_i,
    input wire logic [31:0] hall_offset_i,
    input wire logic config_store_i,
    input wire logic zero_phase_init_i,
    input wire logic signed [15:0] zero_volt_i,
    input wire logic hall_phase_calibrate_i,
    input wire logic servo_on_cmd_i,
    input wire logic motor_off_cmd_i,
    input wire logic signed [2:0] motor_type_select_i,
    input wire logic [4:0] step_smoothing_i,
    input wire logic signed [ACC_W-1:0] step_rate_i,
    output logic [N_AXES*3-1:0] phase2_output_o,
    output logic signed [15:0] phase1_level_o,
    output logic signed [15:0] phase2_level_o,
    output logic setup_done_o,
    output logic wiring_ok_o,
    output logic [31:0] approx_cycle_o,
    output logic [5:0] hall_order_o,
    output logic [31:0] hall_offset_found_o,
    output logic config_store_o,
    output logic [63:0] config_data_o,
    output logic phase_valid_o,
    output logic [31:0] phase_o,
    output logic signed [POS_W-1:0] zero_phase_distance_o,
    output logic motor_off_state_o,
    output logic servo_on_state_o,
    output logic motor_enable_o,
    output logic step_pulse_first_axis_o,
    output logic step_direction_first_axis_o,
    output logic aux_encoder_enable_o,
    output logic position_filter_enable_o,
    output logic signed [POS_W-1:0] commanded_position_report_o,
    output logic signed [POS_W-1:0] step_count_report_o,
    output logic signed [POS_W-1:0] encoder_position_report_o
);
    cas_state_t state_reg;
    logic [31:0] cycle_reg, offset_reg, phase_reg, phase_next;
    logic [31:0] est_phase, delta_fx;
    logic phase_valid_reg, hall_pending_reg, cal_armed_reg, servo_reg;
    logic [2:0] hall_last_reg, sector_now, sector_last;
    logic [3:0] n12;
    logic [15:0] ms_reg;
    logic [$clog2(CYC_MS+1)-1:0] cyc_reg;
    logic signed [POS_W-1:0] pos_last_reg, pos_a_reg, delta_ab;
    logic [2:0] hall_a_reg;
    logic hall_seen_reg, tick_end;
    logic signed [15:0] volt_reg;
    logic stepper, pulse_low;

    // Output pairing: second phases fill the top outputs in axis order
    always_comb begin
        logic [3:0] cnt;
        logic [3:0] rank;
        cnt = '0;
        rank = '0;
        phase2_output_o = '0;
        for (int i = 0; i < N_AXES; i++) begin
            cnt = cnt + 4'(sine_axis_mask_i[i]);
        end
        for (int i = 0; i < N_AXES; i++) begin
            if (sine_axis_mask_i[i]) begin
                phase2_output_o[i*3 +: 3] = 3'(N_AXES - int'(cnt) + int'(rank));
                rank = rank + 4'h1;
            end
        end
    end

    // Hall code to 60 degree sector index
    function automatic logic [2:0] hall_sector(input logic [2:0] h);
        unique case (h)
            3'b001: hall_sector = 3'd0;
            3'b011: hall_sector = 3'd1;
            3'b010: hall_sector = 3'd2;
            3'b110: hall_sector = 3'd3;
            3'b100: hall_sector = 3'd4;
            3'b101: hall_sector = 3'd5;
            default: hall_sector = 3'd7;
        endcase
    endfunction

    assign sector_now = hall_sector(hall_i);
    assign sector_last = hall_sector(hall_last_reg);

    // Phase point in twelfths: sector centre after reset, sector edge on calibration
    always_comb begin
        logic [35:0] prod;
        logic [32:0] sum;
        prod = '0;
        sum = '0;
        // Twelfths reach eleven, so the index needs four bits
        if (hall_pending_reg) begin
            n12 = 4'(sector_now) * 4'd2 + 4'd1;
        end else if (sector_now == ((sector_last == 3'd5) ? 3'd0 : sector_last + 3'd1)) begin
            n12 = 4'(sector_now) * 4'd2;
        end else begin
            n12 = 4'(sector_last) * 4'd2;
        end
        prod = (36'(cycle_reg) * 36'(n12)) / 36'(TWELFTHS);
        sum = 33'(prod[31:0]) + 33'(offset_reg);
        est_phase = (sum >= 33'(cycle_reg) && cycle_reg != '0) ?
            32'(sum - 33'(cycle_reg)) : sum[31:0];
    end

    // Magnetic cycle length and Hall offset storage
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cycle_reg <= CYCLE_RST;
            offset_reg <= OFFSET_RST;
        end else begin
            if (cycle_len_load_i) cycle_reg <= magnetic_cycle_length_i;
            if (hall_offset_load_i) offset_reg <= hall_offset_i;
        end
    end

    // Phase tracking follows encoder motion with wrap at the cycle length
    assign delta_fx = 32'(encoder_position_i - pos_last_reg) << FRAC_W;
    always_comb begin
        logic [31:0] p;
        p = phase_reg + delta_fx;
        if (delta_fx[31] && p[31]) begin
            phase_next = p + cycle_reg;
        end else if (!p[31] && p >= cycle_reg && cycle_reg != '0) begin
            phase_next = p - cycle_reg;
        end else begin
            phase_next = p;
        end
    end

    // Timer that counts the requested milliseconds
    assign tick_end = (cyc_reg == ($bits(cyc_reg))'(CYC_MS - 1)) && (ms_reg <= 16'h0_001);

    // Sequencer for setup test and zero-phase drive
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_reg <= CAS_IDLE;
            cyc_reg <= '0;
            ms_reg <= '0;
            volt_reg <= '0;
            pos_a_reg <= '0;
            hall_a_reg <= '0;
            hall_seen_reg <= 1'b0;
            setup_done_o <= 1'b0;
            wiring_ok_o <= 1'b0;
            approx_cycle_o <= '0;
            hall_order_o <= '0;
            hall_offset_found_o <= '0;
        end else begin
            setup_done_o <= 1'b0;
            cyc_reg <= (cyc_reg == ($bits(cyc_reg))'(CYC_MS - 1)) ? '0 : cyc_reg + 1'b1;
            if (cyc_reg == ($bits(cyc_reg))'(CYC_MS - 1) && ms_reg != '0) ms_reg <= ms_reg - 1'b1;
            unique case (state_reg)
                CAS_IDLE: begin
                    cyc_reg <= '0;
                    if (setup_start_i) begin
                        state_reg <= CAS_TEST_A;
                        ms_reg <= setup_ms_i;
                        volt_reg <= setup_volt_i;
                        hall_seen_reg <= 1'b0;
                    end else if (zero_phase_init_i) begin
                        state_reg <= CAS_ZERO;
                        ms_reg <= setup_ms_i;
                        volt_reg <= zero_volt_i;
                    end
                end
                CAS_TEST_A: begin
                    if (tick_end) begin
                        state_reg <= CAS_TEST_B;
                        ms_reg <= setup_ms_i;
                        pos_a_reg <= encoder_position_i;
                        hall_a_reg <= hall_i;
                    end
                end
                CAS_TEST_B: begin
                    if (hall_i != hall_a_reg && !hall_seen_reg) begin
                        hall_seen_reg <= 1'b1;
                        hall_offset_found_o <= 32'(encoder_position_i - pos_a_reg) << FRAC_W;
                    end
                    if (tick_end) begin
                        state_reg <= CAS_IDLE;
                        setup_done_o <= 1'b1;
                        wiring_ok_o <= (delta_ab > 0);
                        approx_cycle_o <= 32'((delta_ab < 0 ? -delta_ab : delta_ab) << 2) << FRAC_W;
                        hall_order_o <= {hall_a_reg, hall_i};
                    end
                end
                CAS_ZERO: begin
                    if (tick_end) state_reg <= CAS_IDLE;
                end
            endcase
        end
    end
    assign delta_ab = encoder_position_i - pos_a_reg;

    // Phase register, validity and Hall based estimation
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            phase_reg <= '0;
            phase_valid_reg <= 1'b0;
            hall_pending_reg <= 1'b1;
            cal_armed_reg <= 1'b0;
            hall_last_reg <= '0;
            pos_last_reg <= encoder_position_i; // No false motion step after reset
        end else begin
            pos_last_reg <= encoder_position_i;
            hall_last_reg <= hall_i;
            phase_reg <= phase_next;
            hall_pending_reg <= 1'b0;
            if (hall_phase_calibrate_i) cal_armed_reg <= 1'b1;
            if (hall_pending_reg && hall_present_i && sector_now != 3'd7) begin
                phase_reg <= est_phase;
                phase_valid_reg <= 1'b1;
            end else if (state_reg == CAS_ZERO && tick_end) begin
                phase_reg <= '0;
                phase_valid_reg <= 1'b1;
            end else if (cal_armed_reg && hall_i != hall_last_reg &&
                         sector_now != 3'd7 && sector_last != 3'd7) begin
                phase_reg <= est_phase;
                phase_valid_reg <= 1'b1;
                cal_armed_reg <= hall_phase_calibrate_i; // New arming wins over disarm
            end
        end
    end

    // Drive levels: phase one at zero angle, phase two at quarter cycle
    always_comb begin
        phase1_level_o = '0;
        phase2_level_o = '0;
        if (state_reg == CAS_TEST_A) phase1_level_o = volt_reg;
        if (state_reg == CAS_TEST_B) phase2_level_o = volt_reg;
        if (state_reg == CAS_ZERO) phase1_level_o = (volt_reg < 0) ? -volt_reg : volt_reg;
    end

    // Motor on and off state, zero init ends by voltage sign
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            servo_reg <= 1'b0;
        end else if (state_reg == CAS_ZERO && tick_end) begin
            servo_reg <= volt_reg[15];
        end else if (motor_off_cmd_i) begin
            servo_reg <= 1'b0;
        end else if (servo_on_cmd_i) begin
            servo_reg <= 1'b1;
        end
    end
    assign motor_off_state_o = !servo_reg;
    assign servo_on_state_o = servo_reg;
    assign motor_enable_o = (servo_reg && phase_valid_reg) || state_reg != CAS_IDLE;
    assign phase_valid_o = phase_valid_reg;
    assign phase_o = phase_reg;

    // Counts from zero phase to here, shorter way; a move of minus this reaches zero
    always_comb begin
        if (phase_reg > (cycle_reg >> 1)) begin
            zero_phase_distance_o = -POS_W'((cycle_reg - phase_reg) >> FRAC_W);
        end else begin
            zero_phase_distance_o = POS_W'(phase_reg >> FRAC_W);
        end
    end

    // Configuration store pulse with cycle length and Hall offset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            config_store_o <= 1'b0;
            config_data_o <= '0;
        end else begin
            config_store_o <= config_store_i;
            if (config_store_i) config_data_o <= {cycle_reg, offset_reg};
        end
    end

    // Stepper mode and feedback routing
    assign stepper = motor_type_select_i == MTYPE_STEP_LOW || motor_type_select_i == MTYPE_STEP_HIGH;
    assign pulse_low = motor_type_select_i == MTYPE_STEP_LOW;
    assign aux_encoder_enable_o = !stepper;
    assign position_filter_enable_o = !stepper;
    assign encoder_position_report_o = encoder_position_i;

    // Step generator: smoothed rate, accumulator MSB gives half-period pulses
    logic signed [ACC_W+FRAC_W-1:0] rate_reg, rate_diff;
    logic [ACC_W-1:0] acc_reg, inc;
    logic dir_reg, pulse_reg;
    logic signed [POS_W-1:0] steps_reg;
    logic [2:0] shift;
    always_comb begin
        if (step_smoothing_i >= SMOOTH_8) shift = 3'd4;
        else if (step_smoothing_i >= SMOOTH_4) shift = 3'd3;
        else if (step_smoothing_i >= SMOOTH_2) shift = 3'd2;
        else if (step_smoothing_i >= SMOOTH_1) shift = 3'd1;
        else shift = 3'd0;
        rate_diff = ((ACC_W+FRAC_W)'(step_rate_i) <<< FRAC_W) - rate_reg;
        inc = rate_reg[ACC_W+FRAC_W-1] ? ACC_W'((-rate_reg) >>> FRAC_W) :
            ACC_W'(rate_reg >>> FRAC_W);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rate_reg <= '0;
            acc_reg <= '0;
            dir_reg <= 1'b0;
            pulse_reg <= 1'b0;
            steps_reg <= '0;
        end else if (stepper) begin
            rate_reg <= rate_reg + (rate_diff >>> shift);
            pulse_reg <= acc_reg[ACC_W-1];
            if (!acc_reg[ACC_W-1] && dir_reg != rate_reg[ACC_W+FRAC_W-1] && inc != '0) begin
                dir_reg <= rate_reg[ACC_W+FRAC_W-1];
            end else if (dir_reg == rate_reg[ACC_W+FRAC_W-1] || acc_reg[ACC_W-1]) begin
                acc_reg <= acc_reg + inc;
            end
            if (acc_reg[ACC_W-1] && !pulse_reg) begin
                steps_reg <= dir_reg ? steps_reg - 1 : steps_reg + 1;
            end
        end else begin
            rate_reg <= '0;
            acc_reg <= '0;
            pulse_reg <= 1'b0;
        end
    end
    assign step_pulse_first_axis_o = pulse_reg ^ pulse_low;
    assign step_direction_first_axis_o = dir_reg;
    assign commanded_position_report_o = steps_reg;
    assign step_count_report_o = steps_reg;
endmodule

//--- cas_commutation_step_asserts.sv
// Purpose: Port level checks for the commutation and step output block
// Assumes: One clock domain, synchronous active low reset
// Notes: Bound to every instance of the block, sees its ports only
`timescale 1ns/1ns
module cas_commutation_step_asserts import cas_pkg::*; #(
    parameter int N_AXES = 7,
    parameter int CYC_MS = CYC_PER_MS,
    parameter int ACC_W = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hall_present_i,
    input wire logic [2:0] hall_i,
    input wire logic setup_start_i,
    input wire logic signed [15:0] setup_volt_i,
    input wire logic config_store_i,
    input wire logic zero_phase_init_i,
    input wire logic signed [15:0] zero_volt_i,
    input wire logic signed [2:0] motor_type_select_i,
    input wire logic signed [15:0] phase1_level_o,
    input wire logic signed [15:0] phase2_level_o,
    input wire logic setup_done_o,
    input wire logic config_store_o,
    input wire logic phase_valid_o,
    input wire logic step_pulse_first_axis_o,
    input wire logic step_direction_first_axis_o,
    input wire logic aux_encoder_enable_o,
    input wire logic position_filter_enable_o,
    input wire logic signed [POS_W-1:0] commanded_position_report_o,
    input wire logic signed [POS_W-1:0] step_count_report_o
);
    logic idle;
    logic step_act;
    logic signed [15:0] zero_mag;
    // Sequencer counts as idle while neither phase is driven
    assign idle = (phase1_level_o == 16'sh0000) && (phase2_level_o == 16'sh0000);
    // Asserted level of the step pulse follows the selected polarity
    assign step_act = (motor_type_select_i == MTYPE_STEP_LOW) ? !step_pulse_first_axis_o
        : step_pulse_first_axis_o;
    assign zero_mag = (zero_volt_i < 0) ? -zero_volt_i : zero_volt_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    start_drives_a: assert property (
        setup_start_i && idle |=> phase1_level_o == $past(setup_volt_i))
        else $error("setup test did not drive phase one");
    zero_drives_a: assert property (
        zero_phase_init_i && !setup_start_i && idle |=> phase1_level_o == $past(zero_mag))
        else $error("zero init did not drive phase one");
    done_single_a: assert property (setup_done_o |=> !setup_done_o)
        else $error("setup done longer than one cycle");
    store_follow_a: assert property (config_store_i |=> config_store_o)
        else $error("store request not passed on");
    store_cause_a: assert property (config_store_o |-> $past(config_store_i))
        else $error("store strobe without request");
    stepper_quiet_a: assert property (
        (motor_type_select_i == MTYPE_STEP_LOW || motor_type_select_i == MTYPE_STEP_HIGH)
        |-> !aux_encoder_enable_o && !position_filter_enable_o)
        else $error("aux encoder or filter active on stepper");
    dir_hold_a: assert property (
        step_act && $past(step_act) |-> $stable(step_direction_first_axis_o))
        else $error("direction moved during step pulse");
    count_at_pulse_a: assert property (
        $changed(step_count_report_o) |-> ##[0:1] $rose(step_act))
        else $error("step count moved without pulse start");
    report_tie_a: assert property (
        commanded_position_report_o == step_count_report_o)
        else $error("commanded position differs from step count");
    hall_boot_a: assert property (
        $rose(nrst_i) && hall_present_i && hall_i != 3'h0 && hall_i != 3'h7 |=> phase_valid_o)
        else $error("no phase estimate after reset with halls");
    // Main scenarios reached
    setup_seen_c: cover property (setup_done_o);
    store_seen_c: cover property (config_store_o);
    pulse_seen_c: cover property ($rose(step_act));
endmodule
bind cas_commutation_step cas_commutation_step_asserts #(.N_AXES(N_AXES), .CYC_MS(CYC_MS),
    .ACC_W(ACC_W)) u_chk (.*);

//--- cas_motor_model.sv
// Purpose: Behavioural amplifier, motor, encoder and Hall sensor set
// Assumes: Rotor settles toward the energised phase within a few clocks
// Notes: swap_i crosses the phase wiring, jog_i adds outside travel
`timescale 1ns/1ns
module cas_motor_model #(
    parameter int CYCLE = 1200
) (
    input wire logic clk_i,
    input wire logic signed [15:0] phase1_level_i,
    input wire logic signed [15:0] phase2_level_i,
    input wire logic swap_i,
    input wire logic signed [7:0] jog_i,
    output logic signed [31:0] encoder_position_o,
    output logic [2:0] hall_o
);
    int pos = 100;
    int step;
    int sector;
    // Phase one pulls to phase zero, phase two a quarter cycle away
    always @(posedge clk_i) begin
        step = 0;
        if (phase1_level_i != 0) begin
            step = -pos;
        end else if (phase2_level_i != 0) begin
            step = (swap_i ? -CYCLE / 4 : CYCLE / 4) - pos;
        end
        step = (step > 40) ? 40 : ((step < -40) ? -40 : step);
        pos <= pos + step + int'(jog_i);
    end
    // Six Hall sectors of sixty degrees per magnetic cycle
    always_comb begin
        sector = (((pos % CYCLE) + CYCLE) % CYCLE) * 6 / CYCLE;
        case (sector)
            0: hall_o = 3'h1;
            1: hall_o = 3'h3;
            2: hall_o = 3'h2;
            3: hall_o = 3'h6;
            4: hall_o = 3'h4;
            default: hall_o = 3'h5;
        endcase
    end
    assign encoder_position_o = 32'(pos);
endmodule

//--- commutation_and_step_output_tb.sv
// Purpose: Self-checking bench for the commutation and step output block
// Assumes: Inputs change 10 ns after each rising edge
// Notes: One millisecond is shortened to four clocks
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module commutation_and_step_output_tb import cas_pkg::*;;
    logic clk_i = 1'b0;
    logic nrst_i, cycle_len_load_i, hall_present_i, setup_start_i, hall_offset_load_i, swap;
    logic config_store_i, zero_phase_init_i, hall_phase_calibrate_i, servo_on_cmd_i, dir0;
    logic motor_off_cmd_i, setup_done_o, wiring_ok_o, config_store_o, phase_valid_o;
    logic motor_off_state_o, servo_on_state_o, step_pulse_first_axis_o, motor_enable_o;
    logic step_direction_first_axis_o, aux_encoder_enable_o, position_filter_enable_o;
    logic [6:0] sine_axis_mask_i;
    logic [2:0] hall_i;
    logic [4:0] step_smoothing_i;
    logic [5:0] hall_order_o;
    logic [15:0] setup_ms_i;
    logic [20:0] phase2_output_o;
    logic [31:0] magnetic_cycle_length_i, hall_offset_i, approx_cycle_o, phase_o, hall_offset_found_o;
    logic [63:0] config_data_o;
    logic signed [2:0] motor_type_select_i;
    logic signed [7:0] jog;
    logic signed [15:0] setup_volt_i, zero_volt_i, step_rate_i, phase1_level_o, phase2_level_o;
    logic signed [31:0] encoder_position_i, step_count_report_o, t;
    logic signed [31:0] zero_phase_distance_o, commanded_position_report_o, encoder_position_report_o;
    int err_total = 0, total_checks = 0, cycles = 0, n, cnt;
    int act [2];
    // Block under test and the motor behind it
    cas_commutation_step #(.CYC_MS(4)) uut (.*);
    cas_motor_model u_motor (.clk_i(clk_i), .phase1_level_i(phase1_level_o),
        .phase2_level_i(phase2_level_o), .swap_i(swap), .jog_i(jog),
        .encoder_position_o(encoder_position_i), .hall_o(hall_i));
    always #50 clk_i = ~clk_i;
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #10;
    endtask
    task automatic do_reset(input logic hp);
        nrst_i = 1'b0;
        hall_present_i = hp;
        tick(4);
        nrst_i = 1'b1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        {sine_axis_mask_i, cycle_len_load_i, setup_start_i, hall_offset_load_i} = '0;
        {config_store_i, zero_phase_init_i, hall_phase_calibrate_i, servo_on_cmd_i} = '0;
        {motor_off_cmd_i, motor_type_select_i, step_smoothing_i, step_rate_i, swap} = '0;
        {magnetic_cycle_length_i, hall_offset_i, setup_volt_i, zero_volt_i} = '0;
        setup_ms_i = 16'h0003;
        jog = 8'sh00;
        do_reset(1'b1);
        tick(2);
        `CHK(phase_valid_o, 1'b1)
        sine_axis_mask_i = 7'h05;
        tick(1);
        `CHK(phase2_output_o, 21'h00_0185)
        sine_axis_mask_i = 7'h01;
        tick(1);
        `CHK(phase2_output_o, 21'h00_0006)
        $display("test phase pairing done");
        magnetic_cycle_length_i = 32'h0005_3555;
        hall_offset_i = 32'h0000_1400;
        {cycle_len_load_i, hall_offset_load_i} = 2'h3;
        tick(1);
        {cycle_len_load_i, hall_offset_load_i, config_store_i} = 3'h1;
        tick(1);
        config_store_i = 1'b0;
        `CHK(config_store_o, 1'b1)
        `CHK(config_data_o, 64'h0005_3555_0000_1400)
        tick(1);
        `CHK(config_store_o, 1'b0)
        $display("test fractional cycle and store done");
        magnetic_cycle_length_i = 32'h0004_B000;
        cycle_len_load_i = 1'b1;
        setup_volt_i = 16'sh0002;
        tick(1);
        cycle_len_load_i = 1'b0;
        for (int i = 0; i < 2; i++) begin
            swap = 1'(i);
            setup_start_i = 1'b1;
            tick(1);
            setup_start_i = 1'b0;
            `CHK(phase1_level_o, 16'sh0002)
            n = 0;
            while (setup_done_o !== 1'b1 && n < 200) begin
                tick(1);
                n++;
            end
            `CHK(setup_done_o, 1'b1)
            `CHK(wiring_ok_o, 1'(i == 0))
            `CHK(approx_cycle_o, 32'h0004_B000)
            `CHK(hall_order_o, ((i == 0) ? 6'h0B : 6'h0C))
            `CHK(hall_offset_found_o, ((i == 0) ? 32'h0000_C800 : 32'hFFFF_D800))
        end
        $display("test setup wiring done");
        for (int i = 0; i < 2; i++) begin
            zero_volt_i = (i == 0) ? -16'sh0002 : 16'sh0001;
            zero_phase_init_i = 1'b1;
            tick(1);
            zero_phase_init_i = 1'b0;
            `CHK(phase1_level_o, ((i == 0) ? 16'sh0002 : 16'sh0001))
            n = 0;
            while (phase1_level_o !== 16'sh0000 && n < 200) begin
                tick(1);
                n++;
            end
            `CHK(phase1_level_o, 16'sh0000)
            tick(1);
            `CHK(phase_o, 32'h0000_0000)
            `CHK(servo_on_state_o, 1'(i == 0))
            `CHK(motor_off_state_o, 1'(i == 1))
        end
        servo_on_cmd_i = 1'b1;
        tick(1);
        {servo_on_cmd_i, motor_off_cmd_i} = 2'h1;
        `CHK(servo_on_state_o, 1'b1)
        `CHK(motor_enable_o, 1'b1)
        tick(1);
        motor_off_cmd_i = 1'b0;
        `CHK(motor_off_state_o, 1'b1)
        $display("test zero phase done");
        do_reset(1'b0);
        {cycle_len_load_i, servo_on_cmd_i} = 2'h3;
        tick(1);
        {cycle_len_load_i, servo_on_cmd_i} = 2'h0;
        tick(1);
        `CHK(phase_valid_o, 1'b0)
        `CHK(motor_enable_o, 1'b0)
        {hall_present_i, hall_phase_calibrate_i} = 2'h3;
        tick(1);
        hall_phase_calibrate_i = 1'b0;
        jog = 8'sh05;
        n = 0;
        while (phase_valid_o !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        jog = 8'sh00;
        `CHK(phase_valid_o, 1'b1)
        `CHK(phase_o, 32'h0000_C800)
        `CHK(zero_phase_distance_o, 32'h0000_00C8)
        `CHK(motor_enable_o, 1'b1)
        $display("test hall calibration done");
        tick(1);
        `CHK({aux_encoder_enable_o, position_filter_enable_o}, 2'h3)
        motor_type_select_i = MTYPE_STEP_LOW;
        tick(2);
        `CHK(step_pulse_first_axis_o, 1'b1)
        `CHK({aux_encoder_enable_o, position_filter_enable_o}, 2'h0)
        motor_type_select_i = MTYPE_STEP_HIGH;
        tick(2);
        `CHK(step_pulse_first_axis_o, 1'b0)
        step_smoothing_i = 5'h01;
        step_rate_i = 16'sh1000;
        tick(64);
        cnt = 0;
        t = step_count_report_o;
        repeat (256) begin
            tick(1);
            cnt += int'(step_pulse_first_axis_o);
        end
        `CHK(cnt, 32'h0000_0080)
        `CHK(step_count_report_o - t, 32'sh0000_0010)
        `CHK(commanded_position_report_o - t, 32'sh0000_0010)
        `CHK(encoder_position_report_o, encoder_position_i)
        dir0 = step_direction_first_axis_o;
        step_rate_i = -16'sh1000;
        tick(64);
        `CHK(step_direction_first_axis_o ^ dir0, 1'b1)
        $display("test step output done");
        for (int i = 0; i < 2; i++) begin
            step_smoothing_i = (i == 0) ? 5'h01 : SMOOTH_8;
            step_rate_i = 16'sh1000;
            do_reset(1'b1);
            act[i] = 0;
            repeat (16) begin
                tick(1);
                act[i] += int'(step_pulse_first_axis_o);
            end
        end
        `CHK(1'(act[1] < act[0]), 1'b1)
        $display("test step smoothing done");
        final_report();
    end
endmodule
